// ==== include/ldfc_pkg.sv ====
// constants and carrier types for the led dimming and fault control core
package ldfc_pkg;
  localparam int NCH = 4;
  localparam int BW  = 16;
  localparam int AW  = 4;

  // register offsets
  localparam logic [AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [AW-1:0] REG_BRIGHT = 4'h1;
  localparam logic [AW-1:0] REG_SLOPE  = 4'h2;
  localparam logic [AW-1:0] REG_HYBRID = 4'h3;
  localparam logic [AW-1:0] REG_FMASK  = 4'h4;
  localparam logic [AW-1:0] REG_FFLAG  = 4'h5;
  localparam logic [AW-1:0] REG_STATUS = 4'h6;
  localparam logic [AW-1:0] REG_CDUTY0 = 4'h8;
  localparam logic [AW-1:0] REG_CCUR0  = 4'hC;

  // control field positions
  localparam int CTL_CLUSTER = 0;
  localparam int CTL_SRCREG  = 1;
  localparam int CTL_SLOPE   = 2;
  localparam int CTL_DITHER  = 3;
  localparam int CTL_HYBRID  = 4;
  localparam int CTL_FSYNC   = 5;
  localparam int CTL_FREQLO  = 8;
  localparam int CTL_DERLO   = 12;

  // fault bit positions
  localparam int F_VINOV  = 0;
  localparam int F_VINUV  = 1;
  localparam int F_VINOC  = 2;
  localparam int F_BSTOC  = 3;
  localparam int F_BSTOV  = 4;
  localparam int F_LED    = 5;
  localparam int F_TSD    = 6;
  localparam int F_VDDUV  = 7;
  localparam int NFLT     = 8;
  localparam logic [NFLT-1:0] FLT_RECOV = 8'h07;

  // reset values and the fixed current below the hybrid switch point
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [BW-1:0] BRIGHT_RST = 16'hFFFF;
  localparam logic [15:0] SLOPE_RST  = 16'h0010;
  localparam logic [BW-1:0] HYBRID_RST = 16'h4000;
  localparam logic [NFLT-1:0] FMASK_RST  = 8'h00;
  localparam logic [BW-1:0] HYB_LOWCUR = 16'h4000;

  // timing
  localparam longint CLK_HZ       = 200000000;
  localparam longint RETRY_MS     = 100;
  localparam longint RETRY_CYCLES = CLK_HZ * RETRY_MS / 1000;
  localparam int     MEAS_W       = 20;
  localparam int     CNT_W        = 14;
  localparam int     TMP_W        = 8;
  localparam int     DER_SHIFT    = 2;

  // pwm period in core cycles per frequency code: 4883 Hz .. 39063 Hz
  localparam int PERIOD_W = 16;
  typedef logic [PERIOD_W-1:0] ldfc_period_t;
  localparam ldfc_period_t PERIOD_TAB [16] = '{
    16'h9FFF, 16'h4FFF, 16'h3A2F, 16'h2DB7, 16'h27FF, 16'h25A5, 16'h23A3, 16'h21B0,
    16'h1FFF, 16'h1E7A, 16'h1D15, 16'h1BCF, 16'h1AAA, 16'h1998, 16'h16DA, 16'h13FF};
  localparam logic [3:0] RES_TAB [16] = '{
    4'hD, 4'hC, 4'hB, 4'hB, 4'hB, 4'hA, 4'hA, 4'hA,
    4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA};

  typedef enum logic [1:0] {DRV_RUN, DRV_OFF, DRV_RETRY} ldfc_drv_e;

  // fault inputs from analog comparators
  typedef struct packed {
    logic [NFLT-1:0] cond;
  } ldfc_fault_s;

  // per-channel drive outputs
  typedef struct packed {
    logic [NCH-1:0]        on;
    logic [NCH-1:0][BW-1:0] current;
  } ldfc_drive_s;
endpackage : ldfc_pkg

// ==== hw/ldfc_core.sv ====
// led dimming, phase-shifted pwm, hybrid dimming, fault and derating control
module ldfc_core
  import ldfc_pkg::*;
#(
  parameter longint RetryCycles = RETRY_CYCLES
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            clkEn,
  // register port
  input  wire logic [AW-1:0]   regAddr,
  input  wire logic [15:0]     regWdata,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output logic      [15:0]     regRdata,
  // host pins
  input  wire logic            pwmIn,
  input  wire logic            frameSync,
  input  wire logic            fault_clear_in,
  output logic                 faultOut,
  // analog side
  input  ldfc_fault_s          faultIn,
  input  wire logic [TMP_W-1:0] dieTemp,
  output ldfc_drive_s          drive,
  output logic                 lineSwitchOn,
  output logic                 adaptiveBoostEn,
  output logic                 running
);
  logic [15:0]         ctrl_r, slope_r;
  logic [BW-1:0]       bright_r, hybrid_r;
  logic [NFLT-1:0]     fmask_r, fflag_r;
  logic [NCH-1:0][BW-1:0] cDuty_r, cCur_r;
  logic [MEAS_W-1:0]   measCnt_r, measHigh_r;
  logic [BW-1:0]       pinBright_r, level_r;
  logic [15:0]         slopeCnt_r;
  logic [PERIOD_W-1:0] pwmCnt_r;
  logic [BW-1:0]       ditherAcc_r;
  logic                pwmInD_r, syncD_r, fclrD_r;
  logic [31:0]         retryCnt_r;
  ldfc_drv_e           drvState_r;
  logic [NFLT-1:0]     active;
  logic                cluster, wrCtrl;
  logic [3:0]          freqSel;
  logic [BW-1:0]       target, dutyG, curG, derated;
  ldfc_period_t        period;
  logic [3:0]          res;

  assign cluster = ctrl_r[CTL_CLUSTER];
  assign freqSel = ctrl_r[CTL_FREQLO +: 4];
  assign period  = PERIOD_TAB[freqSel];
  assign res     = RES_TAB[freqSel];
  assign active  = faultIn.cond & ~fmask_r;
  assign wrCtrl  = clkEn & regWr;

  // configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r   <= CTRL_RST;
      bright_r <= BRIGHT_RST;
      slope_r  <= SLOPE_RST;
      hybrid_r <= HYBRID_RST;
      fmask_r  <= FMASK_RST;
      cDuty_r  <= '0;
      cCur_r   <= '0;
    end else if (wrCtrl) begin
      case (regAddr)
        REG_CTRL:   ctrl_r   <= regWdata;
        REG_BRIGHT: bright_r <= regWdata;
        REG_SLOPE:  slope_r  <= regWdata;
        REG_HYBRID: hybrid_r <= regWdata;
        REG_FMASK:  fmask_r  <= regWdata[NFLT-1:0];
        default: begin
          if (regAddr[3:2] == REG_CDUTY0[3:2])
            cDuty_r[regAddr[1:0]] <= regWdata;
          else if (regAddr[3:2] == REG_CCUR0[3:2])
            cCur_r[regAddr[1:0]] <= regWdata;
        end
      endcase
    end
  end

  // sticky fault flags; a new event wins over the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fclrD_r <= 1'b0;
      fflag_r <= '0;
    end else if (clkEn) begin
      fclrD_r <= fault_clear_in;
      if ((regWr && regAddr == REG_FFLAG) || (fault_clear_in && !fclrD_r))
        // a clear edge clears all flags, even when a write to another register coincides
        fflag_r <= (fflag_r & ~((fault_clear_in && !fclrD_r) ? {NFLT{1'b1}}
                                                              : regWdata[NFLT-1:0])) | active;
      else
        fflag_r <= fflag_r | active;
    end
  end

  assign faultOut = |fflag_r | |active;

  // read port: data in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdata <= '0;
    end else if (clkEn) begin
      regRdata <= '0;
      if (regRd) begin
        case (regAddr)
          REG_CTRL:   regRdata <= ctrl_r;
          REG_BRIGHT: regRdata <= bright_r;
          REG_SLOPE:  regRdata <= slope_r;
          REG_HYBRID: regRdata <= hybrid_r;
          REG_FMASK:  regRdata <= {8'h00, fmask_r};
          REG_FFLAG:  regRdata <= {8'h00, fflag_r};
          REG_STATUS: regRdata <= level_r;
          default: begin
            if (regAddr[3:2] == REG_CDUTY0[3:2])
              regRdata <= cDuty_r[regAddr[1:0]];
            else if (regAddr[3:2] == REG_CCUR0[3:2])
              regRdata <= cCur_r[regAddr[1:0]];
          end
        endcase
      end
    end
  end

  // input duty measurement, one result per input period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwmInD_r    <= 1'b0;
      measCnt_r   <= '0;
      measHigh_r  <= '0;
      pinBright_r <= '0;
    end else if (clkEn) begin
      pwmInD_r <= pwmIn;
      if (pwmIn && !pwmInD_r) begin
        // measurement ratio kept simple: high/period scaled to 16 bits
        if (measCnt_r != '0)
          pinBright_r <= BW'((({measHigh_r, 16'h0000} - {20'h0, measHigh_r})) / measCnt_r);
        measCnt_r  <= MEAS_W'(1);
        measHigh_r <= MEAS_W'(1);
      end else if (measCnt_r != '1) begin
        measCnt_r <= measCnt_r + MEAS_W'(1);
        if (pwmIn)
          measHigh_r <= measHigh_r + MEAS_W'(1);
      end
    end
  end

  assign target = ctrl_r[CTL_SRCREG] ? bright_r : pinBright_r;

  // sloper: one lsb per slope_r + 1 cycles, bypassed in cluster mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_r    <= '0;
      slopeCnt_r <= '0;
    end else if (clkEn) begin
      if (!ctrl_r[CTL_SLOPE] || cluster) begin
        level_r    <= target;
        slopeCnt_r <= '0;
      end else if (slopeCnt_r >= slope_r) begin
        slopeCnt_r <= '0;
        if (level_r < target)
          level_r <= level_r + BW'(1);
        else if (level_r > target)
          level_r <= level_r - BW'(1);
      end else begin
        slopeCnt_r <= slopeCnt_r + 16'h0001;
      end
    end
  end

  // hybrid split of the display level into duty and current
  always_comb begin
    if (ctrl_r[CTL_HYBRID] && level_r >= hybrid_r) begin
      dutyG = '1;
      curG  = level_r;
    end else if (ctrl_r[CTL_HYBRID]) begin
      curG  = HYB_LOWCUR;
      dutyG = (hybrid_r == '0) ? '1 : BW'((32'(level_r) << 16) / (32'(hybrid_r) + 32'd1));
    end else begin
      curG  = '1;
      dutyG = level_r;
    end
  end

  // die temperature derating scales current by three quarters
  assign derated = BW'(curG - (curG >> DER_SHIFT));

  // pwm counter, restarted by frame sync when enabled and not in cluster mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwmCnt_r    <= '0;
      syncD_r     <= 1'b0;
      ditherAcc_r <= '0;
    end else if (clkEn) begin
      syncD_r <= frameSync;
      if (ctrl_r[CTL_FSYNC] && frameSync && !syncD_r && !cluster)
        pwmCnt_r <= '0;
      else if (pwmCnt_r >= period)
        pwmCnt_r <= '0;
      else
        pwmCnt_r <= pwmCnt_r + PERIOD_W'(1);
      if (pwmCnt_r >= period)
        ditherAcc_r <= ditherAcc_r + (dutyG & ~(16'hFFFF << (BW - res)));
    end
  end

  // per-channel compare with phase offset of period/4 per channel
  logic [NCH-1:0][BW-1:0] chDuty;
  logic [NCH-1:0][BW-1:0] chCur;
  logic [BW-1:0] qDuty;
  logic ditherBit;
  assign ditherBit = ctrl_r[CTL_DITHER] && !cluster &&
                     ({1'b0, ditherAcc_r} + {1'b0, dutyG & ~(16'hFFFF << (BW - res))}) > 17'h0FFFF;
  // duty quantised to the resolution of the selected frequency
  assign qDuty = (dutyG >> (BW - res)) + BW'(ditherBit);

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chDuty[c] = cluster ? cDuty_r[c] : qDuty;
      chCur[c]  = cluster ? cCur_r[c] : derated;
      if (dieTemp <= ctrl_r[CTL_DERLO +: 4] * 8'd10 + 8'd90 - 8'd10 ||
          ctrl_r[CTL_DERLO +: 4] == 4'h0)
        chCur[c] = cluster ? cCur_r[c] : curG;
      else if (cluster)
        chCur[c] = BW'(cCur_r[c] - (cCur_r[c] >> DER_SHIFT));
    end
  end

  logic [NCH-1:0][PERIOD_W-1:0] phaseCnt;
  logic [NCH-1:0][31:0] thr;
  logic                 fullOn;
  // above the switch point, with dither off, the compare alone would leave one off cycle per period
  assign fullOn = !cluster && ctrl_r[CTL_HYBRID] && (level_r >= hybrid_r);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive <= '0;
    end else if (clkEn) begin
      for (int c = 0; c < NCH; c++) begin
        drive.current[c] <= running ? chCur[c] : '0;
        drive.on[c] <= running && ((32'(phaseCnt[c]) < thr[c]) || fullOn);
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      // shifted counter so each channel starts its on-phase a quarter later
      phaseCnt[c] = PERIOD_W'((32'(pwmCnt_r) + 32'(period) + 32'd1 -
                    (32'(period) + 32'd1) * c / NCH) % (32'(period) + 32'd1));
      if (!cluster && !ctrl_r[CTL_DITHER])
        thr[c] = ((32'(period) + 32'd1) * 32'(dutyG)) >> 16;
      else if (cluster)
        thr[c] = ((32'(period) + 32'd1) * 32'(chDuty[c])) >> 16;
      else
        thr[c] = ((32'(period) + 32'd1) * 32'(chDuty[c])) >> res;
    end
  end

  // power-line switch with timed retry of recoverable faults
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drvState_r <= DRV_RUN;
      retryCnt_r <= '0;
    end else if (clkEn) begin
      case (drvState_r)
        DRV_RUN: if (|(active & FLT_RECOV)) begin
          drvState_r <= DRV_OFF;
          retryCnt_r <= '0;
        end
        DRV_OFF: if (retryCnt_r >= 32'(RetryCycles - 1)) begin
          drvState_r <= DRV_RETRY;
          retryCnt_r <= '0;
        end else begin
          retryCnt_r <= retryCnt_r + 32'd1;
        end
        DRV_RETRY: drvState_r <= (|(active & FLT_RECOV)) ? DRV_OFF : DRV_RUN;
        default: drvState_r <= DRV_RUN;
      endcase
    end
  end

  assign lineSwitchOn    = drvState_r != DRV_OFF;
  assign running         = (drvState_r == DRV_RUN) && !active[F_TSD] && !active[F_VDDUV];
  assign adaptiveBoostEn = !cluster && running;
endmodule : ldfc_core

// ==== testbench/ldfc_core_asserts.sv ====
// concurrent checks on the ports of the led dimming and fault core
module ldfc_core_asserts
  import ldfc_pkg::*;
#(
  parameter longint RetryCycles = RETRY_CYCLES
) (
  // watched ports
  input wire logic            core_clk,
  input wire logic            rst,
  input wire logic            clkEn,
  input wire logic [AW-1:0]   regAddr,
  input wire logic [15:0]     regWdata,
  input wire logic            regWr,
  input wire logic            regRd,
  input logic      [15:0]     regRdata,
  input wire logic            fault_clear_in,
  input logic                 faultOut,
  input ldfc_fault_s          faultIn,
  input ldfc_drive_s          drive,
  input logic                 lineSwitchOn,
  input logic                 adaptiveBoostEn,
  input logic                 running
);
  logic [15:0]      ctrlR;
  logic [NFLT-1:0]  maskR;
  longint           offCnt;

  // shadow of the control and mask registers, fed from the write strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlR <= CTRL_RST;
      maskR <= FMASK_RST;
    end else if (clkEn && regWr) begin
      if (regAddr == REG_CTRL) ctrlR <= regWdata;
      if (regAddr == REG_FMASK) maskR <= regWdata[NFLT-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      offCnt <= 0;
    end else if (clkEn) begin
      offCnt <= lineSwitchOn ? 0 : offCnt + 1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_read_idle: assert property (clkEn && !regRd |=> regRdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_unmapped_zero: assert property (clkEn && regRd && regAddr == 4'h7 |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_fault_shown: assert property ((faultIn.cond & ~maskR) != 0 |-> faultOut)
    else $error("fault present but fault output low");
  chk_flag_sticky: assert property ($fell(faultOut) && maskR == 0 |->
      $past(regWr) || $past(fault_clear_in) || $past(fault_clear_in, 2))
    else $error("fault output dropped without a clear");
  chk_ov_opens: assert property ($rose(faultIn.cond[F_VINOV]) && !maskR[F_VINOV]
      |-> ##[0:2] !lineSwitchOn)
    else $error("line switch stays on under input overvoltage");
  chk_tsd_stops: assert property ($rose(faultIn.cond[F_TSD]) && !maskR[F_TSD]
      |-> ##[0:2] !running)
    else $error("still running under over temperature");
  chk_retry_gap: assert property ($rose(lineSwitchOn)
      |-> offCnt >= RetryCycles - 1 && offCnt <= RetryCycles + 1)
    else $error("line switch retry interval wrong");
  chk_cluster_boost: assert property (ctrlR[CTL_CLUSTER] && $past(ctrlR[CTL_CLUSTER])
      |-> !adaptiveBoostEn)
    else $error("adaptive boost active in cluster mode");
  chk_phase_apart: assert property (ctrlR[CTL_CLUSTER] && $past(ctrlR[CTL_CLUSTER]) && running
      |-> $countones(drive.on & ~$past(drive.on)) <= 1)
    else $error("two channels switched on together");

  cover property ($rose(lineSwitchOn));
  cover property ($fell(faultOut));
  cover property (ctrlR[CTL_CLUSTER] && drive.on != 0);
endmodule : ldfc_core_asserts

// ==== testbench/ldfc_host_model.sv ====
// host side: brightness pwm and refresh pulse generator
module ldfc_host_model
  import ldfc_pkg::*;
#(
  parameter int Period = 5120
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // duty in cycles of one period
  input wire logic [15:0] highCycles,
  // host pins
  output logic            pwmIn,
  output logic            frameSync
);
  logic [15:0] cnt;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= (cnt == 16'(Period - 1)) ? 16'h0000 : cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwmIn     <= 1'b0;
      frameSync <= 1'b0;
    end else begin
      pwmIn     <= (cnt < highCycles);
      frameSync <= (cnt == 16'h0000);
    end
  end
endmodule : ldfc_host_model

// ==== testbench/ldfc_core_tb.sv ====
// self-checking bench for the led dimming and fault core
module ldfc_core_tb
  import ldfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // short retry and the fastest pwm period keep the run brief
  localparam longint RC  = 50;
  localparam int     PER = 5120;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [AW-1:0]     regAddr = 4'h0;
  logic [15:0]       regWdata = 16'h0000;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic              fault_clear_in = 1'b0;
  ldfc_fault_s       faultIn = '0;
  logic [TMP_W-1:0]  dieTemp = 8'h19;
  logic [15:0]       regRdata;
  logic              faultOut;
  ldfc_drive_s       drive;
  logic              lineSwitchOn;
  logic              adaptiveBoostEn;
  logic              running;
  logic              pwmIn;
  logic              frameSync;
  int                failures = 0;
  int                checked = 0;

  always #2.5 core_clk = ~core_clk;

  ldfc_core #(.RetryCycles(RC)) ldfc_core_i (.core_clk, .rst, .clkEn(1'b1), .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .pwmIn, .frameSync, .fault_clear_in, .faultOut,
    .faultIn, .dieTemp, .drive, .lineSwitchOn, .adaptiveBoostEn, .running);
  ldfc_host_model #(.Period(PER)) ldfc_host_model_i (.core_clk, .rst,
    .highCycles(16'h0800), .pwmIn, .frameSync);

  task automatic close_out;
    $display("counts checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // gap cycle after each write so strobes never toggle twice in one step
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    cyc(1);
    regWr <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [15:0] exp);
    regAddr <= a;
    regRd   <= 1'b1;
    cyc(1);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk(regRdata, exp);
    @(posedge core_clk);
  endtask : rd

  task automatic on_count(output int c [NCH]);
    c = '{default: 0};
    repeat (PER) begin
      cyc(1);
      for (int i = 0; i < NCH; i++) c[i] += int'(drive.on[i]);
    end
  endtask : on_count

  task automatic t_regs;
    rd(REG_CTRL, CTRL_RST);
    rd(REG_BRIGHT, BRIGHT_RST);
    rd(REG_SLOPE, SLOPE_RST);
    rd(REG_HYBRID, HYBRID_RST);
    rd(REG_FMASK, 16'(FMASK_RST));
    wr(4'h7, 16'hA5A5);
    rd(4'h7, 16'h0000);
    wr(REG_HYBRID, 16'h3000);
    rd(REG_HYBRID, 16'h3000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_cluster;
    int c [NCH];
    int e;
    wr(REG_CTRL, 16'h0F01);
    for (int i = 0; i < NCH; i++) begin
      wr(REG_CDUTY0 + AW'(i), 16'(16'h3000 * (i + 1)));
      wr(REG_CCUR0 + AW'(i), 16'(16'h1000 * (i + 1)));
    end
    cyc(2 * PER);
    chk(drive.current, {16'h4000, 16'h3000, 16'h2000, 16'h1000});
    chk(adaptiveBoostEn, 1'b0);
    on_count(c);
    for (int i = 0; i < NCH; i++) begin
      e = PER * 3 * (i + 1) / 16;
      chk(c[i] >= e - 80 && c[i] <= e + 80, 1'b1);
    end
    $display("test cluster done");
  endtask : t_cluster

  task automatic t_hybrid;
    int c [NCH];
    logic [BW-1:0] cur;
    wr(REG_CTRL, 16'h1F12);
    wr(REG_BRIGHT, 16'hFFFF);
    cyc(2 * PER);
    on_count(c);
    chk(c[0] + c[3], 2 * PER);
    cur = drive.current[0];
    dieTemp <= 8'h5F;
    cyc(PER);
    chk(drive.current[0] < cur, 1'b1);
    dieTemp <= 8'h19;
    wr(REG_BRIGHT, 16'h1000);
    cyc(2 * PER);
    chk(drive.current[0], HYB_LOWCUR);
    on_count(c);
    chk(c[0] > 0 && c[0] < PER, 1'b1);
    $display("test hybrid done");
  endtask : t_hybrid

  task automatic t_display;
    wr(REG_CTRL, 16'h0F20);
    cyc(2 * PER);
    rd(REG_STATUS, 16'h6666);
    wr(REG_CTRL, 16'h0F26);
    cyc(170);
    regAddr <= REG_STATUS;
    regRd   <= 1'b1;
    cyc(1);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk(regRdata < 16'h6666 && regRdata > 16'h6650, 1'b1);
    @(posedge core_clk);
    $display("test display done");
  endtask : t_display

  task automatic t_retry;
    int n;
    faultIn.cond[F_VINOV] <= 1'b1;
    cyc(3);
    chk(lineSwitchOn, 1'b0);
    faultIn.cond[F_VINOV] <= 1'b0;
    n = 0;
    while (lineSwitchOn !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n >= 200) begin
      failures++;
      close_out();
    end
    chk(n >= RC - 4 && n <= RC, 1'b1);
    cyc(5);
    chk(lineSwitchOn, 1'b1);
    wr(REG_FFLAG, 16'h00FF);
    $display("test retry done");
  endtask : t_retry

  task automatic t_fault;
    faultIn.cond[F_LED] <= 1'b1;
    cyc(2);
    chk(faultOut, 1'b1);
    rd(REG_FFLAG, 16'h0020);
    faultIn.cond[F_LED] <= 1'b0;
    cyc(2);
    chk(faultOut, 1'b1);
    wr(REG_FFLAG, 16'h0020);
    chk(faultOut, 1'b0);
    rd(REG_FFLAG, 16'h0000);
    faultIn.cond[F_BSTOV] <= 1'b1;
    cyc(2);
    faultIn.cond[F_BSTOV] <= 1'b0;
    cyc(2);
    fault_clear_in <= 1'b1;
    cyc(3);
    chk(faultOut, 1'b0);
    fault_clear_in <= 1'b0;
    wr(REG_FMASK, 16'h0040);
    faultIn.cond[F_TSD] <= 1'b1;
    cyc(3);
    chk(running, 1'b1);
    wr(REG_FMASK, 16'h0000);
    cyc(3);
    chk(running, 1'b0);
    $display("test fault done");
  endtask : t_fault

  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    t_regs();
    t_cluster();
    t_hybrid();
    t_display();
    t_retry();
    t_fault();
    close_out();
  end
endmodule : ldfc_core_tb

bind ldfc_core ldfc_core_asserts #(.RetryCycles(RetryCycles)) ldfc_core_asserts_i (.core_clk,
  .rst, .clkEn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .fault_clear_in, .faultOut,
  .faultIn, .drive, .lineSwitchOn, .adaptiveBoostEn, .running);
